// ### inc/pds_pkg.sv
//------------------------------------------------------------------------------
// shared types and constants of the power-down sequencer
//------------------------------------------------------------------------------
package pds_pkg;

    //--------------------------------------------------------------------------
    // regulator set
    //--------------------------------------------------------------------------
    localparam int PDS_NREG         = 7;        // number of sequenced outputs
    localparam int PDS_SLOT_W       = 3;        // width of one slot setting
    localparam int PDS_IDX_BUCK1    = 0;        // buck1_off_slot position
    localparam int PDS_IDX_BUCK2    = 1;        // buck2_off_slot position
    localparam int PDS_IDX_BUCK3    = 2;        // buck3_off_slot position
    localparam int PDS_IDX_LINREG1  = 3;        // linreg1_off_slot position
    localparam int PDS_IDX_LINREG2  = 4;        // linreg2_off_slot position
    localparam int PDS_IDX_LINREG3  = 5;        // linreg3_off_slot position
    localparam int PDS_IDX_MEMREF   = 6;        // memref_off_slot position

    //--------------------------------------------------------------------------
    // timing
    //--------------------------------------------------------------------------
    localparam int PDS_CLK_KHZ      = 20000;    // 20 MHz system clock
    localparam int PDS_UP_FAST_US   = 500;      // power-up slot, speed bit 0
    localparam int PDS_UP_SLOW_US   = 2000;     // power-up slot, speed bit 1
    localparam int PDS_OFF_GAP_US   = 2000;     // power-down slot spacing
    localparam int PDS_RST_UNIT_US  = 2000;     // reset release delay unit
    localparam int PDS_RST_MIN_MS   = 2;        // shortest reset release delay
    localparam int PDS_RST_MAX_MS   = 1024;     // longest reset release delay
    localparam int PDS_UP_FAST_CYC  = PDS_UP_FAST_US * PDS_CLK_KHZ / 1000;
    localparam int PDS_UP_SLOW_CYC  = PDS_UP_SLOW_US * PDS_CLK_KHZ / 1000;
    localparam int PDS_OFF_GAP_CYC  = PDS_OFF_GAP_US * PDS_CLK_KHZ / 1000;
    localparam int PDS_RST_UNIT_CYC = PDS_RST_UNIT_US * PDS_CLK_KHZ / 1000;
    localparam int PDS_TMR_W        = 17;       // holds the longest slot count
    localparam int PDS_RCNT_W       = 10;       // reset delay unit counter

    //--------------------------------------------------------------------------
    // reset values
    //--------------------------------------------------------------------------
    localparam logic [PDS_NREG-1:0] PDS_ENABLE_RST = 7'h00;  // all regulators off
    localparam logic                PDS_CPU_RST_N  = 1'h0;   // processor held

    //--------------------------------------------------------------------------
    // types
    //--------------------------------------------------------------------------
    typedef logic [PDS_SLOT_W-1:0]                pds_slot_type;
    typedef logic [PDS_NREG-1:0][PDS_SLOT_W-1:0]  pds_slots_type;
    typedef logic [PDS_NREG-1:0]                  pds_mask_type;

    // target of a power-down request
    typedef enum logic [1:0] {
        PDS_TO_STANDBY,
        PDS_TO_SLEEP,
        PDS_TO_OFF
    } pds_kind_type;

    // power-down request from the state machine
    typedef struct packed {
        logic         valid;  // one-cycle request
        pds_kind_type kind;   // destination state
        pds_mask_type mask;   // regulators that go off for standby or sleep; PDS_TO_OFF turns off all enabled
    } pds_down_req_type;

    // power-up request from the state machine
    typedef struct packed {
        logic         valid;  // one-cycle request
        pds_mask_type mask;   // regulators on in run
    } pds_up_req_type;

    // processor write of one off slot
    typedef struct packed {
        logic                      valid;  // one-cycle write strobe
        logic [2:0]                index;  // regulator position
        pds_slot_type              value;  // new slot setting
    } pds_slot_wr_type;

    // reset release delay in 2 ms units per select code
    function automatic logic [PDS_RCNT_W-1:0] pds_rst_units(input logic [2:0] sel);
        logic [PDS_RCNT_W-1:0] u;
        case (sel)
            3'h0:    u = 10'h001;
            3'h1:    u = 10'h002;
            3'h2:    u = 10'h004;
            3'h3:    u = 10'h008;
            3'h4:    u = 10'h010;
            3'h5:    u = 10'h020;
            3'h6:    u = 10'h040;
            default: u = 10'h200;
        endcase
        return u;
    endfunction : pds_rst_units

endpackage : pds_pkg

// ### verilog/pds_slot_timer.sv
`timescale 1ns/10ps
`default_nettype none
//------------------------------------------------------------------------------
// slot time base: one tick every period cycles after start
//------------------------------------------------------------------------------
module pds_slot_timer #(
    parameter int TW = 17                   // counter width
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset,
    // control
    input  wire logic          start,       // restart the period now
    input  wire logic [TW-1:0] period,      // cycles per tick
    // result
    output logic               tick         // one-cycle pulse
);

    logic [TW-1:0] cnt_r;                   // cycles left in this period
    logic          tick_r;                  // registered tick

    //--------------------------------------------------------------------------
    // down counter, reloads itself so long delays see repeated ticks
    //--------------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end
        else if (start)
        begin
            cnt_r  <= period - TW'(1);
            tick_r <= 1'b0;
        end
        else if (cnt_r == TW'(1))
        begin
            cnt_r  <= period;
            tick_r <= 1'b1;
        end
        else
        begin
            cnt_r  <= (cnt_r != '0) ? cnt_r - TW'(1) : cnt_r;
            tick_r <= 1'b0;
        end
    end

    assign tick = tick_r;

endmodule : pds_slot_timer
`default_nettype wire

// ### verilog/pds_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module pds_sequencer
    import pds_pkg::*;
#(
    parameter int UP_FAST_CYC  = pds_pkg::PDS_UP_FAST_CYC,   // 0.5 ms slot
    parameter int UP_SLOW_CYC  = pds_pkg::PDS_UP_SLOW_CYC,   // 2.0 ms slot
    parameter int OFF_GAP_CYC  = pds_pkg::PDS_OFF_GAP_CYC,   // 2.0 ms gap
    parameter int RST_UNIT_CYC = pds_pkg::PDS_RST_UNIT_CYC   // 2 ms unit
) (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset,
    // fused configuration
    input  wire pds_pkg::pds_slots_type    fused_on_slots,
    input  wire logic                      slot_period_select,
    input  wire logic [2:0]                reset_release_delay_sel,
    // processor access to off slots
    input  wire pds_pkg::pds_slot_wr_type  off_slot_wr,
    output pds_pkg::pds_slots_type         off_slots,
    // state machine requests
    input  wire pds_pkg::pds_up_req_type   up_req,
    input  wire pds_pkg::pds_down_req_type down_req,
    input  wire logic                      voltage_ramp_busy,
    // regulator and processor controls
    output pds_pkg::pds_mask_type          reg_enable,
    output logic                           processor_reset_out_n,
    // status
    output logic                           shutdown_done_flag,
    output logic                           startup_done_flag,
    output logic                           seq_busy
);

    //--------------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------------
    typedef enum {
        ST_OFF,         // regulators disabled
        ST_UP_STEP,     // switch on next slot
        ST_UP_WAIT,     // power-up slot time
        ST_RST_WAIT,    // processor reset release delay
        ST_RUN,         // system running
        ST_DN_STEP,     // switch off next slot
        ST_DN_WAIT,     // power-down slot gap
        ST_SETTLE,      // wait for voltage ramps, then report except after PDS_TO_OFF
        ST_LOW          // standby or sleep resting
    } pds_state_type;

    localparam logic [PDS_TMR_W-1:0] FAST_P = PDS_TMR_W'(UP_FAST_CYC);
    localparam logic [PDS_TMR_W-1:0] SLOW_P = PDS_TMR_W'(UP_SLOW_CYC);
    localparam logic [PDS_TMR_W-1:0] GAP_P  = PDS_TMR_W'(OFF_GAP_CYC);
    localparam logic [PDS_TMR_W-1:0] UNIT_P = PDS_TMR_W'(RST_UNIT_CYC);

    pds_state_type         state_r, state_nxt;   // sequencer state
    pds_mask_type          rem_r, rem_nxt;       // regulators still to step
    pds_mask_type          en_r, en_nxt;         // regulator enables
    logic                  cpu_r, cpu_nxt;       // processor reset, low held
    pds_kind_type          kind_r, kind_nxt;     // current power-down target
    logic                  from_off_r, from_off_nxt;  // power-up from disabled
    logic                  up_dir_r, up_dir_nxt; // settle belongs to power-up
    logic [PDS_RCNT_W-1:0] rcnt_r, rcnt_nxt;     // reset delay units left
    logic                  dnf_r, dnf_nxt;       // shutdown done pulse
    logic                  upf_r, upf_nxt;       // startup done pulse
    logic                  busy_r, busy_nxt;     // sequencing in progress
    pds_slots_type         slots_r;              // off slot settings
    logic                  load_r;               // fused copy still pending
    logic                  tmr_start;            // restart slot timer
    logic [PDS_TMR_W-1:0]  tmr_period;           // timer period for restart
    logic                  tick;                 // slot timer tick

    //--------------------------------------------------------------------------
    // slot selection helpers
    //--------------------------------------------------------------------------
    // highest (hi set) or lowest slot among the masked regulators
    function automatic pds_slot_type pick_slot(input pds_slots_type s,
                                               input pds_mask_type  m,
                                               input logic          hi);
        pds_slot_type r;
        r = hi ? '0 : '1;
        for (int i = 0; i < PDS_NREG; i++)
        begin
            if (m[i] && (hi ? (s[i] > r) : (s[i] < r)))
                r = s[i];
        end
        return r;
    endfunction : pick_slot

    //--------------------------------------------------------------------------
    // decode
    //--------------------------------------------------------------------------
    wire pds_slot_type dn_cur   = pick_slot(slots_r, rem_r, 1'b1);
    wire pds_slot_type up_cur   = pick_slot(fused_on_slots, rem_r, 1'b0);
    wire               all_zero = (slots_r == '0);
    wire               sys_on   = (state_r == ST_RUN) || (state_r == ST_LOW);
    wire pds_mask_type dn_mask  = (down_req.kind == PDS_TO_OFF) ? en_r
                                                                : (down_req.mask & en_r);
    wire pds_mask_type up_left;
    wire pds_mask_type dn_left;
    pds_mask_type      dn_hit;                                       // slot members off
    pds_mask_type      up_hit;                                       // slot members on

    // regulators in the current slot switch together
    generate
        for (genvar g = 0; g < PDS_NREG; g++)
        begin : g_hit
            assign dn_hit[g] = rem_r[g] && (slots_r[g] == dn_cur);
            assign up_hit[g] = rem_r[g] && (fused_on_slots[g] == up_cur);
        end
    endgenerate

    assign up_left = rem_r & ~up_hit;
    assign dn_left = rem_r & ~dn_hit;

    //--------------------------------------------------------------------------
    // slot timer
    //--------------------------------------------------------------------------
    pds_slot_timer #(
        .TW     (PDS_TMR_W)
    ) u_timer (
        .clk    (clk),
        .reset  (reset),
        .start  (tmr_start),
        .period (tmr_period),
        .tick   (tick)
    );

    //--------------------------------------------------------------------------
    // sequencer next state
    //--------------------------------------------------------------------------
    always_comb
    begin
        state_nxt    = state_r;
        rem_nxt      = rem_r;
        en_nxt       = en_r;
        cpu_nxt      = cpu_r;
        kind_nxt     = kind_r;
        from_off_nxt = from_off_r;
        up_dir_nxt   = up_dir_r;
        rcnt_nxt     = rcnt_r;
        dnf_nxt      = 1'b0;
        upf_nxt      = 1'b0;
        tmr_start    = 1'b0;
        tmr_period   = GAP_P;
        case (state_r)
            // disabled: power-up request starts the fused order
            ST_OFF:
            begin
                if (up_req.valid)
                begin
                    rem_nxt      = up_req.mask;
                    from_off_nxt = 1'b1;
                    up_dir_nxt   = 1'b1;
                    cpu_nxt      = 1'b0;
                    state_nxt    = ST_UP_STEP;
                end
            end
            // standby or sleep: bring back regulators that are off
            ST_LOW:
            begin
                if (up_req.valid)
                begin
                    rem_nxt      = up_req.mask & ~en_r;
                    from_off_nxt = 1'b0;
                    up_dir_nxt   = 1'b1;
                    state_nxt    = ST_UP_STEP;
                end
            end
            // switch on the lowest remaining slot; when none is left, start
            // the reset release delay (from disabled) or go settle
            ST_UP_STEP:
            begin
                en_nxt     = en_r | up_hit;
                rem_nxt    = up_left;
                tmr_start  = (rem_r == '0) ? from_off_r : (up_left != '0);
                tmr_period = (rem_r == '0) ? UNIT_P
                           : (slot_period_select ? SLOW_P : FAST_P);
                rcnt_nxt   = pds_rst_units(reset_release_delay_sel);
                if (rem_r != '0)
                    state_nxt = (up_left == '0) ? ST_UP_STEP : ST_UP_WAIT;
                else
                    state_nxt = from_off_r ? ST_RST_WAIT : ST_SETTLE;
            end
            ST_UP_WAIT:
            begin
                if (tick)
                    state_nxt = ST_UP_STEP;
            end
            // count reset delay units, then release the processor
            ST_RST_WAIT:
            begin
                if (tick)
                begin
                    if (rcnt_r == PDS_RCNT_W'(1))
                    begin
                        cpu_nxt   = 1'b1;
                        state_nxt = ST_RUN;
                    end
                    else
                        rcnt_nxt = rcnt_r - PDS_RCNT_W'(1);
                end
            end
            // run: a power-down request picks its path
            ST_RUN:
            begin
                if (down_req.valid)
                begin
                    kind_nxt   = down_req.kind;
                    rem_nxt    = dn_mask;
                    up_dir_nxt = 1'b0;
                    if (down_req.kind == PDS_TO_OFF)
                        cpu_nxt = 1'b0;
                    if (all_zero)
                    begin
                        en_nxt    = en_r & ~dn_mask;
                        rem_nxt   = '0;
                        state_nxt = ST_SETTLE;
                    end
                    else if (dn_mask == '0)
                        state_nxt = ST_SETTLE;
                    else
                        state_nxt = ST_DN_STEP;
                end
            end
            // switch off the highest remaining slot; slot zero holds all that
            // is left once the top slot reaches zero, so it goes last
            ST_DN_STEP:
            begin
                en_nxt     = en_r & ~dn_hit;
                rem_nxt    = dn_left;
                tmr_start  = (dn_left != '0);
                tmr_period = GAP_P;
                state_nxt  = (dn_left != '0) ? ST_DN_WAIT : ST_SETTLE;
            end
            ST_DN_WAIT:
            begin
                if (tick)
                    state_nxt = ST_DN_STEP;
            end
            // pending voltage ramps still take their time
            ST_SETTLE:
            begin
                if (!voltage_ramp_busy)
                begin
                    upf_nxt   = up_dir_r;
                    dnf_nxt   = !up_dir_r && (kind_r != PDS_TO_OFF);
                    state_nxt = up_dir_r ? ST_RUN
                              : ((kind_r == PDS_TO_OFF) ? ST_OFF : ST_LOW);
                end
            end
            default:
            begin
                state_nxt = ST_OFF;
            end
        endcase
        busy_nxt = !((state_nxt == ST_OFF) || (state_nxt == ST_RUN)
                     || (state_nxt == ST_LOW));
    end

    //--------------------------------------------------------------------------
    // sequencer registers
    //--------------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_r    <= ST_OFF;
            rem_r      <= '0;
            en_r       <= PDS_ENABLE_RST;
            cpu_r      <= PDS_CPU_RST_N;
            kind_r     <= PDS_TO_STANDBY;
            from_off_r <= 1'b0;
            up_dir_r   <= 1'b0;
            rcnt_r     <= '0;
            dnf_r      <= 1'b0;
            upf_r      <= 1'b0;
            busy_r     <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            rem_r      <= rem_nxt;
            en_r       <= en_nxt;
            cpu_r      <= cpu_nxt;
            kind_r     <= kind_nxt;
            from_off_r <= from_off_nxt;
            up_dir_r   <= up_dir_nxt;
            rcnt_r     <= rcnt_nxt;
            dnf_r      <= dnf_nxt;
            upf_r      <= upf_nxt;
            busy_r     <= busy_nxt;
        end
    end

    //--------------------------------------------------------------------------
    // off slot settings: fused copy after reset, then processor writes
    //--------------------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            slots_r <= '0;
            load_r  <= 1'b1;
        end
        else if (load_r)
        begin
            slots_r <= fused_on_slots;
            load_r  <= 1'b0;
        end
        else if (off_slot_wr.valid && sys_on
                 && (off_slot_wr.index < 3'(PDS_NREG)))
            slots_r[off_slot_wr.index] <= off_slot_wr.value;
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign off_slots             = slots_r;
    assign reg_enable            = en_r;
    assign processor_reset_out_n = cpu_r;
    assign shutdown_done_flag    = dnf_r;
    assign startup_done_flag     = upf_r;
    assign seq_busy              = busy_r;

endmodule : pds_sequencer
`default_nettype wire

// ### verification/pds_seq_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pds_seq_chk
    import pds_pkg::*;
(
    // clock and reset
    input wire logic                      clk,
    input wire logic                      reset,
    // watched ports
    input wire pds_pkg::pds_slots_type    fused_on_slots,
    input wire pds_pkg::pds_slot_wr_type  off_slot_wr,
    input wire pds_pkg::pds_slots_type    off_slots,
    input wire pds_pkg::pds_down_req_type down_req,
    input wire pds_pkg::pds_mask_type     reg_enable,
    input wire logic                      processor_reset_out_n,
    input wire logic                      shutdown_done_flag,
    input wire logic                      startup_done_flag,
    input wire logic                      seq_busy
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    chk_shut_pulse: assert property (shutdown_done_flag |=> !shutdown_done_flag)
        else $error("shutdown flag longer than one cycle");
    chk_shut_idle: assert property (shutdown_done_flag |-> !seq_busy && processor_reset_out_n)
        else $error("shutdown flag while busy");
    chk_start_pulse: assert property (startup_done_flag |=> !startup_done_flag)
        else $error("startup flag longer than one cycle");
    chk_fused_load: assert property ($fell(reset) |=> off_slots == fused_on_slots)
        else $error("off slots not loaded from fused slots");
    chk_wr_refused: assert property (off_slot_wr.valid && seq_busy |=> $stable(off_slots))
        else $error("slot write taken while sequencing");
    chk_wr_taken: assert property (off_slot_wr.valid && !seq_busy && processor_reset_out_n
        && off_slot_wr.index != 3'h7 |=> off_slots[$past(off_slot_wr.index)]
        == $past(off_slot_wr.value)) else $error("slot write lost");
    chk_bypass_off: assert property (down_req.valid && !seq_busy && processor_reset_out_n
        && off_slots == '0 && down_req.kind == PDS_TO_SLEEP
        |=> (reg_enable & $past(down_req.mask)) == '0) else $error("bypass not at once");
    chk_down_gap: assert property (seq_busy && |($past(reg_enable) & ~reg_enable)
        |=> !(|($past(reg_enable) & ~reg_enable))[*7]) else $error("off slots too close");
    chk_up_gap: assert property (seq_busy && |(~$past(reg_enable) & reg_enable)
        |=> !(|(~$past(reg_enable) & reg_enable))[*3]) else $error("on slots too close");
    chk_rst_release: assert property ($rose(processor_reset_out_n) |-> $fell(seq_busy)
        && reg_enable == $past(reg_enable, 8)) else $error("reset released early");
endmodule : pds_seq_chk
bind pds_sequencer pds_seq_chk chk (.clk, .reset, .fused_on_slots, .off_slot_wr, .off_slots,
    .down_req, .reg_enable, .processor_reset_out_n, .shutdown_done_flag, .startup_done_flag,
    .seq_busy);
`default_nettype wire

// ### verification/pds_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module pds_cpu_model
    import pds_pkg::*;
(
    // clock and reset
    input wire logic                clk,
    input wire logic                reset,
    // command from the bench
    input wire logic                go,
    input wire logic [2:0]          idx,
    input wire pds_pkg::pds_slot_type val,
    // slot write to the device
    output pds_pkg::pds_slot_wr_type wr
);
    // one-cycle write launched just after the edge
    always_ff @(posedge clk or posedge reset)
        if (reset) wr <= '0;
        else wr <= '{go, idx, val};
endmodule : pds_cpu_model
`default_nettype wire

// ### verification/pds_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pds_sequencer_tb;
    import pds_pkg::*;
    logic clk = 1'h0, reset, go = 1'h0, voltage_ramp_busy = 1'h0, slot_period_select = 1'h0;
    logic [2:0] reset_release_delay_sel = 3'h1, wi = 3'h0;
    pds_slot_type wv = 3'h0;
    pds_slots_type fused_on_slots, off_slots, ex;
    pds_slot_wr_type off_slot_wr;
    pds_up_req_type up_req = '0;
    pds_down_req_type down_req = '0;
    pds_mask_type reg_enable, q[$];
    logic processor_reset_out_n, shutdown_done_flag, startup_done_flag, seq_busy;
    int err_total = 0, n_compared = 0;
    logic [31:0] rs = 32'h32;
    pds_sequencer #(.UP_FAST_CYC(4), .UP_SLOW_CYC(8), .OFF_GAP_CYC(8), .RST_UNIT_CYC(8)) dut (.*);
    pds_cpu_model cpu (.clk, .reset, .go, .idx(wi), .val(wv), .wr(off_slot_wr));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs();
        rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
        return rs;
    endfunction : xs
    task automatic chk(input string nm, input logic [20:0] s, input logic [20:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // one request, expected enables noted when a flag should follow
    task automatic run(input logic d, input pds_kind_type k, input pds_mask_type m,
                       input logic fl, input pds_mask_type e);
        if (d) down_req <= '{1'b1, k, m};
        else up_req <= '{1'b1, m};
        @(posedge clk);
        down_req <= '0; up_req <= '0;
        if (fl) q.push_back(e);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 3000 && seq_busy !== 1'h0; i++) @(posedge clk);
        chk("idle", seq_busy, 1'h0);
        repeat (3) @(posedge clk);
    endtask : run
    // flag watcher takes the oldest note
    always @(posedge clk)
        if (shutdown_done_flag === 1'h1 || startup_done_flag === 1'h1)
        begin
            chk("ramp", voltage_ramp_busy, 1'h0);
            if (q.size() == 0) chk("flag", 1'h1, 1'h0);
            else chk("enable", reg_enable, q.pop_front());
        end
    initial
    begin
        pds_slot_type v;
        reset = 1'h1;
        fused_on_slots = pds_slots_type'(xs());
        ex = fused_on_slots;
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        repeat (3) @(posedge clk);
        chk("slots", off_slots, ex);
        run(1'h0, PDS_TO_OFF, 7'h7F, 1'h0, 7'h00);
        chk("release", processor_reset_out_n, 1'h1);
        chk("on", reg_enable, 7'h7F);
        voltage_ramp_busy <= 1'h1; go <= 1'h1; wv <= 3'h7;
        fork
            begin
                @(posedge clk); go <= 1'h0;
                repeat (150) @(posedge clk); voltage_ramp_busy <= 1'h0;
            end
        join_none
        run(1'h1, PDS_TO_STANDBY, 7'h7F, 1'h1, 7'h00);
        chk("kept", off_slots, ex);
        run(1'h0, PDS_TO_OFF, 7'h7F, 1'h1, 7'h7F);
        run(1'h1, PDS_TO_STANDBY, 7'h00, 1'h1, 7'h7F);
        run(1'h0, PDS_TO_OFF, 7'h7F, 1'h1, 7'h7F);
        for (int p = 0; p < 2; p++)
        begin
            for (int k = 0; k < 8; k++)
            begin
                v = p ? 3'h0 : pds_slot_type'(xs());
                wi <= 3'(k); wv <= v; go <= 1'h1;
                if (k < 7) ex[k] = v;
                @(posedge clk); go <= 1'h0; @(posedge clk);
            end
            repeat (2) @(posedge clk);
            chk("written", off_slots, ex);
            run(1'h1, PDS_TO_SLEEP, 7'h7F, 1'h1, 7'h00);
            run(1'h0, PDS_TO_OFF, 7'h7F, 1'h1, 7'h7F);
        end
        run(1'h1, PDS_TO_OFF, 7'h7F, 1'h0, 7'h00);
        chk("held", processor_reset_out_n, 1'h0);
        chk("all off", reg_enable, 7'h00);
        print_verdict();
    end
    // watchdog
    initial
    begin
        #4000000;
        err_total++;
        print_verdict();
    end
endmodule : pds_sequencer_tb
`default_nettype wire
